// ### core/ccm_pkg.sv
`default_nettype none

package ccm_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses; ctrl, issue, status one word, each bank eight words)
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS   = 8'h00;
    localparam logic [7:0]  ISSUE_OFS  = 8'h04;
    localparam logic [7:0]  STAT_OFS   = 8'h08;
    localparam logic [7:0]  G1_IDX_OFS = 8'h40;
    localparam logic [7:0]  G1_MOD_OFS = 8'h60;
    localparam logic [7:0]  G2_IDX_OFS = 8'h80;
    localparam logic [7:0]  G2_MOD_OFS = 8'ha0;

    // control register fields and reset values
    localparam int          CTRL_DUAL  = 0;
    localparam int          CTRL_BC1   = 1;
    localparam int          CTRL_BC2   = 2;
    localparam int          CTRL_SHORT = 3;
    localparam logic [3:0]  CTRL_RST   = 4'h0;
    localparam logic [31:0] IDX_RST    = 32'h0000_0000;
    localparam logic [31:0] MOD_RST    = 32'h0000_0000;
    localparam logic [31:0] ISSUE_RST  = 32'hf000_0000;

    // secondary element address increments
    localparam logic [31:0] K_NORMAL   = 32'h0000_0001;
    localparam logic [31:0] K_SHORT    = 32'h0000_0002;
    localparam logic [31:0] K_BCAST    = 32'h0000_0000;

    // index slots that honour the broadcast bits
    localparam logic [2:0]  BC_G1_SLOT = 3'h1;
    localparam logic [2:0]  BC_G2_SLOT = 3'h1;

    // ------------------------------------------------------------
    // instruction types, sizes, units
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        T1A = 4'b0000, T1B = 4'b0001, T2A = 4'b0010, T2B = 4'b0011,
        T2C = 4'b0100, T3A = 4'b0101, T3B = 4'b0110, T3C = 4'b0111,
        T4A = 4'b1000, T4B = 4'b1001, T5A = 4'b1010, T5B = 4'b1011,
        T6A = 4'b1100, T7A = 4'b1101, T7B = 4'b1110, TNOP = 4'b1111
    } ccm_type_t;

    typedef enum logic [1:0] {
        SZ48 = 2'b00, SZ32 = 2'b01, SZ16 = 2'b10, SZNONE = 2'b11
    } ccm_size_t;

    typedef enum logic [1:0] {
        U_ALU = 2'b00, U_MUL = 2'b01, U_SHF = 2'b10, U_RSV = 2'b11
    } ccm_unit_t;

    // issue word layout
    typedef struct packed {
        ccm_type_t  kind;
        logic       has_cond;
        logic [4:0] cond_sel;
        ccm_unit_t  unit;
        logic [2:0] g1_i;
        logic [2:0] g1_m;
        logic [2:0] g2_i;
        logic [2:0] g2_m;
        logic       b_dm;
        logic       b_pm;
        logic [5:0] imm6;
    } ccm_instr_t;

    // static class of each type
    typedef struct packed {
        logic condable;
        logic comp;
        logic dual;
        logic single;
        logic immm;
        logic regmv;
        logic modify;
        ccm_size_t size;
    } ccm_cls_t;

    // execution controls handed to the register files and memories
    typedef struct packed {
        logic        valid;
        ccm_size_t   size;
        ccm_unit_t   unit;
        logic        comp_x;
        logic        comp_y;
        logic        dm_en_x;
        logic        dm_en_y;
        logic        pm_en_x;
        logic        pm_en_y;
        logic        dm_wr;
        logic        pm_wr;
        logic        bcast_y;
        logic        move_x;
        logic        move_y;
        logic        swap;
        logic [31:0] dm_addr_x;
        logic [31:0] dm_addr_y;
        logic [31:0] pm_addr_x;
        logic [31:0] pm_addr_y;
    } ccm_exec_t;

    function automatic ccm_cls_t ccm_class(input ccm_type_t t);
        ccm_cls_t c;
        c = '0;
        c.size = SZNONE;
        unique case (t)
            T1A: c = '{0, 1, 1, 0, 0, 0, 0, SZ48};
            T1B: c = '{0, 0, 1, 0, 0, 0, 0, SZ32};
            T2A: c = '{1, 1, 0, 0, 0, 0, 0, SZ48};
            T2B: c = '{0, 1, 0, 0, 0, 0, 0, SZ32};
            T2C: c = '{0, 1, 0, 0, 0, 0, 0, SZ16};
            T3A: c = '{1, 1, 0, 1, 0, 0, 0, SZ48};
            T3B: c = '{1, 0, 0, 1, 0, 0, 0, SZ32};
            T3C: c = '{0, 0, 0, 1, 0, 0, 0, SZ16};
            T4A: c = '{1, 1, 0, 1, 1, 0, 0, SZ48};
            T4B: c = '{1, 0, 0, 1, 1, 0, 0, SZ32};
            T5A: c = '{1, 1, 0, 0, 0, 1, 0, SZ48};
            T5B: c = '{1, 0, 0, 0, 0, 1, 0, SZ32};
            T6A: c = '{1, 1, 0, 1, 0, 0, 0, SZ48};
            T7A: c = '{1, 1, 0, 0, 0, 0, 1, SZ48};
            T7B: c = '{1, 0, 0, 0, 0, 0, 1, SZ32};
            default: c = '{0, 0, 0, 0, 0, 0, 0, SZNONE};
        endcase
        return c;
    endfunction

endpackage

`default_nettype wire

// ### core/ccm_exec.sv
`default_nettype none

// What this block does
// RULE1: a true condition lets both the computation and the data move run.
// RULE2: an instruction without a condition behaves as always true.
// RULE3: the compute field picks alu, multiplier or shifter beside the move.
// RULE4: suffix a is a 48-bit word, b a 32-bit word, c a 16-bit word.
// RULE5: dual move uses gen_one_index for data, gen_two_index for program.
// RULE6: dual moves only post-modify and write back, never pre-modify.
// RULE7: data memory writes via generator one, program via generator two.
// RULE8: type 1b moves data and program memory in parallel, no computation.
// RULE9: dual-element mode runs type 1 on both elements together.
// RULE10: secondary element addresses index plus one, primary index as is.
// RULE11: secondary element uses the complementary data register.
// RULE12: broadcast bit set, read via index slot 1: secondary uses the index without increment.
// RULE13: broadcast read loads the secondary register with the same value.
// RULE14: single-data mode computes type 2a only if primary condition holds.
// RULE15: type 2b computes unconditionally, 2c short 16-bit compute too.
// RULE16: type 4 uses a 6-bit immediate in place of the modifier.
// RULE17: type 5 does a register move or data/complementary swap.
// RULE18: type 6 pairs an immediate shift with a single memory move.
// RULE19: type 7 updates an index by its modifier, optional compute.
// RULE20: each element tests the condition on its own in dual mode.
// RULE21: secondary increment is one normal, two short, zero broadcast.
// RULE22: a false condition suppresses memory enables; index updates are suppressed only when no element executes.
module ccm_exec
    import ccm_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rstn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output var  logic               hreadyout,
    output var  logic [31:0]        hrdata,
    output var  logic               hresp,
    input  wire logic [31:0]        pri_cond,
    input  wire logic [31:0]        sec_cond,
    output var  ccm_pkg::ccm_exec_t exec
);
    import ccm_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] g1_idx_q [8];
    logic [31:0] g1_mod_q [8];
    logic [31:0] g2_idx_q [8];
    logic [31:0] g2_mod_q [8];
    logic [3:0]  ctrl_q;
    logic [31:0] issue_q;
    logic [15:0] count_q;
    logic [1:0]  last_q;
    logic        wr_q;
    logic [7:0]  addr_q;
    logic [31:0] rdata_q;
    ccm_exec_t   exec_q;
    ccm_exec_t   exec_d;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic        take;
    logic [7:0]  ra;
    logic [2:0]  rslot;
    logic [31:0] rd_mux;
    logic [2:0]  wslot;
    logic        w_ctrl;
    logic        w_issue;
    logic        w_g1i;
    logic        w_g1m;
    logic        w_g2i;
    logic        w_g2m;

    function automatic logic in_bank(input logic [7:0] a,
                                     input logic [7:0] base);
        return a[7:5] == base[7:5];
    endfunction

    // address phase is taken on a selected non-idle transfer
    assign take  = hsel & htrans[1] & hready;
    assign ra    = haddr[7:0];
    assign rslot = ra[4:2];
    assign wslot = addr_q[4:2];

    // read selection, unmapped words read zero
    assign rd_mux =
        (ra == CTRL_OFS)          ? {28'h0, ctrl_q} :
        (ra == ISSUE_OFS)         ? issue_q :
        (ra == STAT_OFS)          ? {14'h0, last_q, count_q} :
        in_bank(ra, G1_IDX_OFS)   ? g1_idx_q[rslot] :
        in_bank(ra, G1_MOD_OFS)   ? g1_mod_q[rslot] :
        in_bank(ra, G2_IDX_OFS)   ? g2_idx_q[rslot] :
        in_bank(ra, G2_MOD_OFS)   ? g2_mod_q[rslot] : 32'h0;

    // write strobes in the data phase
    assign w_ctrl  = wr_q & (addr_q == CTRL_OFS);
    assign w_issue = wr_q & (addr_q == ISSUE_OFS);
    assign w_g1i   = wr_q & in_bank(addr_q, G1_IDX_OFS);
    assign w_g1m   = wr_q & in_bank(addr_q, G1_MOD_OFS);
    assign w_g2i   = wr_q & in_bank(addr_q, G2_IDX_OFS);
    assign w_g2m   = wr_q & in_bank(addr_q, G2_MOD_OFS);

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    ccm_instr_t  ins;
    ccm_cls_t    cls;
    logic        dual_m;
    logic        cond_x;
    logic        cond_y;
    logic        ex_x;
    logic        ex_y;
    logic        any_ex;
    logic        pre;
    logic        dm_use;
    logic        pm_use;
    logic        dm_wr;
    logic        pm_wr;
    logic [31:0] i1;
    logic [31:0] i2;
    logic [31:0] m1;
    logic [31:0] m2;
    logic [31:0] imm;
    logic [31:0] ea1;
    logic [31:0] ea2;
    logic        bc1;
    logic        bc2;
    logic [31:0] k1;
    logic [31:0] k2;
    logic        upd1;
    logic        upd2;

    function automatic logic [31:0] kval(input logic bc,
                                         input logic short_w);
        return bc ? K_BCAST : (short_w ? K_SHORT : K_NORMAL);
    endfunction

    assign ins    = ccm_instr_t'(hwdata);
    assign cls    = ccm_class(ins.kind);                    // RULE4
    assign dual_m = ctrl_q[CTRL_DUAL];

    // per element condition, absent condition reads as true
    assign cond_x = ~cls.condable | ~ins.has_cond
                  | pri_cond[ins.cond_sel];                 // RULE1 RULE2
    assign cond_y = ~cls.condable | ~ins.has_cond
                  | sec_cond[ins.cond_sel];                 // RULE20
    assign ex_x   = w_issue & (ins.kind != TNOP) & cond_x;  // RULE14
    assign ex_y   = w_issue & (ins.kind != TNOP)
                  & dual_m & cond_y;                        // RULE9
    assign any_ex = ex_x | ex_y;

    // memory selection and direction
    assign dm_use = cls.dual | (cls.single & ~ins.b_pm);
    assign pm_use = cls.dual | (cls.single & ins.b_pm);
    assign dm_wr  = (ins.kind == T1B) | ins.b_dm;           // RULE8
    assign pm_wr  = (ins.kind == T1B) ? 1'b0
                  : (cls.dual ? ins.b_pm : ins.b_dm);

    // type 3 may pre-modify, type 4 is index relative
    assign pre = cls.immm
               | (cls.single & ~cls.immm & (ins.kind != T6A)
                  & ~cls.dual & ins.imm6[5]
                  & (ins.kind != T3C));                     // RULE6

    // generator operands
    assign imm = {{26{ins.imm6[5]}}, ins.imm6};
    assign i1  = g1_idx_q[ins.g1_i];                        // RULE5
    assign i2  = g2_idx_q[ins.g2_i];
    assign m1  = cls.immm ? imm : g1_mod_q[ins.g1_m];       // RULE16
    assign m2  = cls.immm ? imm : g2_mod_q[ins.g2_m];
    assign ea1 = pre ? i1 + m1 : i1;
    assign ea2 = pre ? i2 + m2 : i2;

    // broadcast reads keep the secondary on the same word
    assign bc1 = ctrl_q[CTRL_BC1] & (ins.g1_i == BC_G1_SLOT)
               & ~dm_wr;                                    // RULE12
    assign bc2 = ctrl_q[CTRL_BC2] & (ins.g2_i == BC_G2_SLOT)
               & ~pm_wr;
    assign k1  = kval(bc1, ctrl_q[CTRL_SHORT]);             // RULE21
    assign k2  = kval(bc2, ctrl_q[CTRL_SHORT]);

    // index write back only when some element executed
    assign upd1 = any_ex & ((dm_use & ~pre & ~cls.immm)
                | (cls.modify & ~ins.b_pm));                // RULE22 RULE19
    assign upd2 = any_ex & ((pm_use & ~pre & ~cls.immm)
                | (cls.modify & ins.b_pm));

    // ------------------------------------------------------------
    // execution controls
    // ------------------------------------------------------------
    always_comb
    begin
        exec_d           = '0;
        exec_d.valid     = w_issue;
        exec_d.size      = cls.size;                        // RULE4
        exec_d.unit      = (ins.kind == T6A) ? U_SHF
                         : ins.unit;                        // RULE3 RULE18
        exec_d.comp_x    = ex_x & cls.comp;                 // RULE15
        exec_d.comp_y    = ex_y & cls.comp;
        exec_d.dm_en_x   = ex_x & dm_use;                   // RULE7
        exec_d.dm_en_y   = ex_y & dm_use;                   // RULE11
        exec_d.pm_en_x   = ex_x & pm_use;
        exec_d.pm_en_y   = ex_y & pm_use;
        exec_d.dm_wr     = dm_wr & dm_use;
        exec_d.pm_wr     = pm_wr & pm_use;
        exec_d.bcast_y   = ex_y & ((dm_use & bc1)
                         | (pm_use & bc2));                 // RULE13
        exec_d.move_x    = ex_x & cls.regmv;                // RULE17
        exec_d.move_y    = ex_y & cls.regmv;
        exec_d.swap      = cls.regmv & ins.b_dm;
        exec_d.dm_addr_x = ea1;
        exec_d.dm_addr_y = ea1 + k1;                        // RULE10
        exec_d.pm_addr_x = ea2;
        exec_d.pm_addr_y = ea2 + k2;
    end

    // ------------------------------------------------------------
    // bus slave flops
    // ------------------------------------------------------------
    // address phase capture and read data, zero wait state
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_q    <= 1'b0;
            addr_q  <= 8'h0;
            rdata_q <= 32'h0;
        end
        else
        begin
            wr_q    <= take & hwrite;
            addr_q  <= ra;
            rdata_q <= (take & ~hwrite) ? rd_mux : 32'h0;
        end
    end

    // control, last issue and status
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q  <= CTRL_RST;
            issue_q <= ISSUE_RST;
            count_q <= 16'h0;
            last_q  <= 2'h0;
        end
        else
        begin
            if (w_ctrl)
                ctrl_q <= hwdata[3:0];
            if (w_issue)
            begin
                issue_q <= hwdata;
                count_q <= count_q + 16'h1;
                last_q  <= {ex_y, ex_x};
            end
        end
    end

    // generator one registers, bus writes or post-modify
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int n = 0; n < 8; n++)
            begin
                g1_idx_q[n] <= IDX_RST;
                g1_mod_q[n] <= MOD_RST;
            end
        end
        else
        begin
            if (w_g1i)
                g1_idx_q[wslot] <= hwdata;
            if (w_g1m)
                g1_mod_q[wslot] <= hwdata;
            if (upd1)
                g1_idx_q[ins.g1_i] <= i1 + m1;              // RULE5
        end
    end

    // generator two registers, bus writes or post-modify
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int n = 0; n < 8; n++)
            begin
                g2_idx_q[n] <= IDX_RST;
                g2_mod_q[n] <= MOD_RST;
            end
        end
        else
        begin
            if (w_g2i)
                g2_idx_q[wslot] <= hwdata;
            if (w_g2m)
                g2_mod_q[wslot] <= hwdata;
            if (upd2)
                g2_idx_q[ins.g2_i] <= i2 + m2;              // RULE5
        end
    end

    // one cycle of execution controls per issue
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            exec_q <= '0;
        else
            exec_q <= exec_d;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic ready_q;
    logic resp_q;

    // always ready, always okay
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ready_q <= 1'b1;
            resp_q  <= 1'b0;
        end
        else
        begin
            ready_q <= 1'b1;
            resp_q  <= 1'b0;
        end
    end

    assign hreadyout = ready_q;
    assign hresp     = resp_q;
    assign hrdata    = rdata_q;
    assign exec      = exec_q;

endmodule

`default_nettype wire

// ### test/ccm_exec_chk.sv
`default_nettype none

// ------------------------------------------------------------
// issue and bus checks
// ------------------------------------------------------------
module ccm_exec_chk
    import ccm_pkg::*;
(
    input wire logic               clock,
    input wire logic               rstn,
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic [31:0]        hwdata,
    input wire logic               hready,
    input wire logic               hreadyout,
    input wire logic [31:0]        hrdata,
    input wire logic               hresp,
    input wire logic [31:0]        pri_cond,
    input wire logic [31:0]        sec_cond,
    input wire ccm_pkg::ccm_exec_t exec
);
    timeunit 1ns;
    timeprecision 100ps;

    logic iss_q;
    logic rd_q;
    wire  take = hsel & htrans[1] & hready;

    // data phase of an issue write or a read
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            iss_q <= 1'b0;
            rd_q  <= 1'b0;
        end
        else
        begin
            iss_q <= take & hwrite & (haddr[7:0] == ISSUE_OFS);
            rd_q  <= take & !hwrite;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // issue word of type t on the write data
    sequence s_iss(logic [3:0] t);
        iss_q && hwdata[31:28] == t;
    endsequence

    // conditional compute failing in one element
    sequence s_cfalse(logic [31:0] c);
        s_iss(4'h2) ##0 hwdata[27] && !c[hwdata[26:22]];
    endsequence

    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or okay");
    chk_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("read data outside a read");
    chk_true_both: assert property (
        s_iss(4'h0) |=> exec.valid && exec.comp_x && exec.dm_en_x
            && exec.pm_en_x && exec.size == SZ48)
        else $error("dual move did not run");
    chk_size_short: assert property (
        s_iss(4'h4) |=> exec.size == SZ16)
        else $error("short compute size");
    chk_dual_nocomp: assert property (
        s_iss(4'h1) |=> !exec.comp_x && exec.dm_wr && !exec.pm_wr
            && exec.size == SZ32)
        else $error("move-only dual wrong");
    chk_pri_false: assert property (
        s_cfalse(pri_cond) |=> !exec.comp_x)
        else $error("primary ran on false");
    chk_sec_false: assert property (
        s_cfalse(sec_cond) |=> !exec.comp_y)
        else $error("secondary ran on false");
    chk_y_offset: assert property (
        exec.dm_en_y && !exec.bcast_y
            |-> (exec.dm_addr_y - exec.dm_addr_x) inside {1, 2})
        else $error("secondary offset");
    chk_bcast_same: assert property (
        exec.bcast_y |-> exec.dm_addr_y == exec.dm_addr_x
            || exec.pm_addr_y == exec.pm_addr_x)
        else $error("broadcast offset");
    chk_comp_only: assert property (
        s_iss(4'h3) |=> exec.comp_x && !exec.dm_en_x && !exec.pm_en_x)
        else $error("plain compute");
    chk_shift_unit: assert property (
        s_iss(4'hc) |=> exec.unit == U_SHF)
        else $error("shift not on shifter");
    chk_modify_nomem: assert property (
        s_iss(4'hd) |=> !exec.dm_en_x && !exec.pm_en_x)
        else $error("modify touched memory");
endmodule

bind ccm_exec ccm_exec_chk u_chk (
    .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .pri_cond(pri_cond), .sec_cond(sec_cond),
    .exec(exec));

`default_nettype wire

// ### test/ccm_mem_model.sv
`default_nettype none

// ------------------------------------------------------------
// data and program memory side
// ------------------------------------------------------------
module ccm_mem_model
    import ccm_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rstn,
    input  wire ccm_pkg::ccm_exec_t exec,
    output var  logic [7:0]         dm_hits,
    output var  logic [7:0]         pm_hits
);
    timeunit 1ns;
    timeprecision 100ps;

    // count each element's access
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            dm_hits <= 8'h00;
            pm_hits <= 8'h00;
        end
        else if (exec.valid)
        begin
            dm_hits <= dm_hits + {7'h0, exec.dm_en_x}
                + {7'h0, exec.dm_en_y};
            pm_hits <= pm_hits + {7'h0, exec.pm_en_x}
                + {7'h0, exec.pm_en_y};
        end
    end
endmodule

`default_nettype wire

// ### test/ccm_tb_top.sv
`default_nettype none

// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module conditional_compute_move_exec_tb_top
    import ccm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [11:0] GSEL = 12'b010_011_000_001;
    localparam logic [7:0]  IX2  = G1_IDX_OFS + 8'h08;

    logic        clock    = 1'b0;
    logic        rstn     = 1'b0;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'b00;
    logic        hwrite   = 1'b0;
    logic [31:0] hwdata   = 32'h0;
    logic [31:0] pri_cond = 32'h0;
    logic [31:0] sec_cond = 32'h0;
    logic [31:0] rd_cap;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [7:0]  dm_hits;
    logic [7:0]  pm_hits;
    ccm_exec_t   exec;
    ccm_exec_t   ex;
    int          bad_count = 0;
    int          checks    = 0;

    always #2.5 clock = ~clock;

    ccm_exec dut (
        .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .pri_cond(pri_cond),
        .sec_cond(sec_cond), .exec(exec));

    ccm_mem_model mem (.clock(clock), .rstn(rstn), .exec(exec),
        .dm_hits(dm_hits), .pm_hits(pm_hits));

    // read data at the end of the data phase
    always @(posedge clock) rd_cap <= hrdata;

    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // address then data phase, each held to hready
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge clock);
        while (hreadyout !== 1'b1)
            @(posedge clock);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clock);
        while (hreadyout !== 1'b1)
            @(posedge clock);
        #1;
        q  = rd_cap;
        ex = exec;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    task automatic iss(input logic [3:0] t, input logic [5:0] c,
                       input logic [1:0] u, input logic [11:0] g,
                       input logic [7:0] b);
        wr(ISSUE_OFS, {t, c, u, g, b});
    endtask

    // reset values, read-only and unmapped
    task automatic t_regs;
        logic [31:0] q;
        rd(CTRL_OFS, q);
        cmp("ctrl", {28'h0, CTRL_RST}, q);
        rd(ISSUE_OFS, q);
        cmp("issue", ISSUE_RST, q);
        wr(STAT_OFS, 32'hffff_ffff);
        rd(STAT_OFS, q);
        cmp("stat", 32'h0, q);
        wr(8'hf0, 32'h1234_5678);
        rd(8'hf0, q);
        cmp("unmapped", 32'h0, q);
    endtask

    // dual move, single-data mode, write-back
    task automatic t_dual;
        logic [31:0] q;
        wr(IX2, 32'h100);
        wr(G1_MOD_OFS + 8'h0c, 32'h4);
        wr(G2_IDX_OFS, 32'h200);
        wr(G2_MOD_OFS + 8'h04, 32'h8);
        iss(4'h0, 6'h00, 2'b00, GSEL, 8'hc0);
        cmp("size", SZ48, ex.size);
        cmp("dm_addr", 32'h100, ex.dm_addr_x);
        cmp("pm_addr", 32'h200, ex.pm_addr_x);
        cmp("wr", 2'b11, {ex.dm_wr, ex.pm_wr});
        cmp("comp_y", 0, ex.comp_y);
        rd(IX2, q);
        cmp("g1_wb", 32'h104, q);
        rd(G2_IDX_OFS, q);
        cmp("g2_wb", 32'h208, q);
    endtask

    // both elements: +1, +2, broadcast
    task automatic t_dual_element_mode;
        sec_cond <= 32'hffff_ffff;
        wr(CTRL_OFS, 32'h1);
        iss(4'h1, 6'h00, 2'b00, GSEL, 8'h00);
        cmp("t1b", 5'b01011, {ex.comp_x, ex.dm_wr, ex.pm_wr,
            ex.dm_en_y, ex.pm_en_y});
        cmp("y_one", 32'h105, ex.dm_addr_y);
        wr(CTRL_OFS, 32'h9);
        iss(4'h0, 6'h00, 2'b00, GSEL, 8'h00);
        cmp("y_two", 32'h10a, ex.dm_addr_y);
        cmp("comp_y", 1, ex.comp_y);
        wr(CTRL_OFS, 32'h3);
        iss(4'h0, 6'h00, 2'b00, 12'b001_000_000_001, 8'h40);
        cmp("bcast", 1, ex.bcast_y);
        cmp("b_addr", 32'h0, ex.dm_addr_y);
        wr(CTRL_OFS, 32'h1);
    endtask

    // per-element conditions, suppression
    task automatic t_cond;
        logic [31:0] v, q;
        logic [7:0]  n;
        pri_cond <= 32'h0;
        sec_cond <= 32'h20;
        iss(4'h2, 6'h25, 2'b01, GSEL, 8'h00);
        cmp("cx_off", 2'b01, {ex.comp_x, ex.comp_y});
        pri_cond <= 32'hffff_ffff;
        sec_cond <= 32'h0;
        iss(4'h2, 6'h25, 2'b01, GSEL, 8'h00);
        cmp("cx_on", 2'b10, {ex.comp_x, ex.comp_y});
        pri_cond <= 32'h0;
        rd(IX2, v);
        n = dm_hits;
        iss(4'h5, 6'h26, 2'b00, GSEL, 8'h00);
        rd(IX2, q);
        cmp("no_wb", v, q);
        cmp("no_mem", n, dm_hits);
        pri_cond <= 32'hffff_ffff;
        iss(4'h5, 6'h26, 2'b00, GSEL, 8'h00);
        rd(IX2, q);
        cmp("wb", v + 32'h4, q);
        cmp("mem", n + 8'h1, dm_hits);
        pri_cond <= 32'h0;
        iss(4'h3, 6'h27, 2'b00, GSEL, 8'h00);
        cmp("t2b", 1, ex.comp_x);
        cmp("t2b_sz", SZ32, ex.size);
        iss(4'h4, 6'h00, 2'b00, GSEL, 8'h00);
        cmp("t2c_sz", SZ16, ex.size);
    endtask

    // units, immediate, move, modify, no-op
    task automatic t_types;
        logic [31:0] v, q;
        wr(CTRL_OFS, 32'h0);
        for (int u = 0; u < 3; u++)
        begin
            iss(4'h2, 6'h00, u[1:0], GSEL, 8'h00);
            cmp("unit", u, ex.unit);
        end
        iss(4'hc, 6'h00, 2'b00, GSEL, 8'h00);
        cmp("t6", {U_SHF, 1'b1}, {ex.unit, ex.dm_en_x});
        rd(IX2, v);
        iss(4'h8, 6'h00, 2'b00, GSEL, 8'h3e);
        cmp("t4_addr", v - 32'h2, ex.dm_addr_x);
        rd(IX2, q);
        cmp("t4_idx", v, q);
        iss(4'ha, 6'h00, 2'b00, GSEL, 8'h80);
        cmp("t5", 2'b11, {ex.move_x, ex.swap});
        iss(4'hd, 6'h00, 2'b00, GSEL, 8'h00);
        rd(IX2, q);
        cmp("t7", v + 32'h4, q);
        iss(4'hf, 6'h00, 2'b00, GSEL, 8'h00);
        cmp("nop", {1'b1, SZNONE}, {ex.valid, ex.size});
    endtask

    task automatic tally_and_finish;
        if (bad_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // main
    initial
    begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        t_regs();
        t_dual();
        t_dual_element_mode();
        t_cond();
        t_types();
        tally_and_finish();
    end

    // watchdog
    initial
    begin
        #20000;
        bad_count++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
